/* common/rxc_defines.svh */
`ifndef RXC_DEFINES_SVH
`define RXC_DEFINES_SVH

// ************************************************************
// clock and timing
// ************************************************************
`define RXC_CLK_HZ 40000000
`define RXC_DONE_MS 2000
`define RXC_PULSE_MS 500
`define RXC_ERASE_ALL_MS 5000
`define RXC_DONE_CYC (`RXC_DONE_MS * (`RXC_CLK_HZ / 1000))
`define RXC_PULSE_CYC (`RXC_PULSE_MS * (`RXC_CLK_HZ / 1000))
`define RXC_ERASE_ALL_CYC (`RXC_ERASE_ALL_MS * (`RXC_CLK_HZ / 1000))

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define RXC_OFS_STATUS 4'h0
`define RXC_OFS_CTRL 4'h4
`define RXC_OFS_INDEX 4'h8
`define RXC_OFS_ENTRY 4'hC

// ************************************************************
// field positions and reset values
// ************************************************************
`define RXC_ST_MODE_LSB 0
`define RXC_ST_SAMPLED_BIT 3
`define RXC_ST_COUNT_LSB 8
`define RXC_ST_RELAY_LSB 16
`define RXC_ST_PIN_A_BIT 24
`define RXC_ST_PIN_B_BIT 25
`define RXC_CTRL_EN_BIT 0
`define RXC_CTRL_RESET 1'h1

`endif

/* common/rxc_pkg.sv */
package rxc_pkg;

    // ************************************************************
    // operating modes
    // ************************************************************
    typedef enum logic [2:0] {
        RXC_ONESHOT,
        RXC_TOGGLE,
        RXC_SWITCH,
        RXC_CONT,
        RXC_REGISTER,
        RXC_ERASE,
        RXC_ERASE_ALL,
        RXC_IDLE
    } rxc_mode_t;

endpackage : rxc_pkg

/* hdl/rxc_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rxc_defines.svh"

module rxc_top #(
    parameter int P_DEPTH = 100,
    parameter logic [31:0] P_DONE_CYC = `RXC_DONE_CYC,
    parameter logic [31:0] P_PULSE_CYC = `RXC_PULSE_CYC,
    parameter logic [31:0] P_ERASE_ALL_CYC = `RXC_ERASE_ALL_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // mode pins
    input wire logic i_set_pin,
    input wire logic i_mode_pin_a,
    output logic o_mode_pin_a,
    output logic o_mode_pin_a_oe,
    input wire logic i_mode_pin_b,
    output logic o_mode_pin_b,
    output logic o_mode_pin_b_oe,
    // received frames
    input wire logic i_frame_valid,
    input wire logic [31:0] i_frame_id,
    input wire logic [5:0] i_frame_sw,
    // relay outputs
    output logic [5:0] o_relay,
    // avalon-mm slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic sampled;
        rxc_pkg::rxc_mode_t mode;
        logic [P_DEPTH-1:0][31:0] ids;
        logic [6:0] count;
        logic [31:0] tmr;
        logic a_low;
        logic a_hold;
        logic b_low;
        logic [5:0] sw_last;
        logic [5:0] relay;
        logic [5:0][31:0] pulse;
        logic ctrl_en;
        logic [6:0] idx;
        logic ack;
        logic [31:0] rdata;
    } rxc_state_t;

    rxc_state_t state_r;
    rxc_state_t state_nxt;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic hit;
        logic [6:0] hidx;
        logic [5:0] rise;
        logic accept;
        hit = 1'b0;
        hidx = 7'h00;
        rise = 6'h00;
        accept = 1'b0;
        state_nxt = state_r;

        // first match among the occupied entries
        for (int i = 0; i < P_DEPTH; i++) begin
            if (!hit && (7'(i) < state_r.count) && (state_r.ids[i] == i_frame_id)) begin
                hit = 1'b1;
                hidx = 7'(i);
            end
        end

        if (!state_r.sampled) begin
            // mode caught once, first edge after reset release
            state_nxt.sampled = 1'b1;
            case ({i_set_pin, i_mode_pin_b, i_mode_pin_a})
                3'h7: state_nxt.mode = rxc_pkg::RXC_ONESHOT;
                3'h6: state_nxt.mode = rxc_pkg::RXC_TOGGLE;
                3'h5: state_nxt.mode = rxc_pkg::RXC_SWITCH;
                3'h4: state_nxt.mode = rxc_pkg::RXC_CONT;
                3'h3: state_nxt.mode = rxc_pkg::RXC_REGISTER;
                3'h2: state_nxt.mode = rxc_pkg::RXC_ERASE;
                3'h1: state_nxt.mode = rxc_pkg::RXC_ERASE_ALL;
                default: state_nxt.mode = rxc_pkg::RXC_IDLE;
            endcase
            if ({i_set_pin, i_mode_pin_b, i_mode_pin_a} == 3'h1) begin
                state_nxt.tmr = P_ERASE_ALL_CYC;
            end
        end else begin
            // timers
            if (state_r.tmr != 32'h0) begin
                state_nxt.tmr = state_r.tmr - 32'h1;
            end
            for (int k = 0; k < 6; k++) begin
                if (state_r.pulse[k] != 32'h0) begin
                    state_nxt.pulse[k] = state_r.pulse[k] - 32'h1;
                end
            end

            case (state_r.mode)
                rxc_pkg::RXC_REGISTER: begin
                    if (i_frame_valid) begin
                        state_nxt.ids[0] = i_frame_id;
                        for (int i = 1; i < P_DEPTH; i++) begin
                            if (!hit || (7'(i) <= hidx)) begin
                                state_nxt.ids[i] = state_r.ids[i-1];
                            end
                        end
                        if (!hit && (state_r.count < 7'(P_DEPTH))) begin
                            state_nxt.count = state_r.count + 7'h01;
                        end
                        state_nxt.tmr = P_DONE_CYC;
                    end
                end
                rxc_pkg::RXC_ERASE: begin
                    if (i_frame_valid && hit) begin
                        for (int i = 0; i < P_DEPTH - 1; i++) begin
                            if (7'(i) >= hidx) begin
                                state_nxt.ids[i] = state_r.ids[i+1];
                            end
                        end
                        state_nxt.count = state_r.count - 7'h01;
                        state_nxt.tmr = P_DONE_CYC;
                    end
                end
                rxc_pkg::RXC_ERASE_ALL: begin
                    if (state_r.tmr == 32'h1) begin
                        state_nxt.count = 7'h00;
                        state_nxt.a_hold = 1'b1;
                    end
                end
                rxc_pkg::RXC_IDLE: begin
                end
                default: begin
                    // normal modes, only listed senders act
                    accept = i_frame_valid && hit && state_r.ctrl_en;
                    if (accept) begin
                        rise = i_frame_sw & ~state_r.sw_last;
                        state_nxt.sw_last = i_frame_sw;
                        case (state_r.mode)
                            rxc_pkg::RXC_ONESHOT: begin
                                for (int k = 0; k < 6; k++) begin
                                    if (rise[k]) begin
                                        state_nxt.pulse[k] = P_PULSE_CYC;
                                    end
                                end
                            end
                            rxc_pkg::RXC_TOGGLE: begin
                                state_nxt.relay = state_r.relay ^ rise;
                            end
                            rxc_pkg::RXC_SWITCH: begin
                                for (int p = 0; p < 3; p++) begin
                                    if (rise[2*p]) begin
                                        state_nxt.relay[3+p] = 1'b1;
                                    end else if (rise[2*p+1]) begin
                                        state_nxt.relay[3+p] = 1'b0;
                                    end
                                end
                                state_nxt.relay[2:0] = 3'h0;
                            end
                            default: begin
                                state_nxt.relay = i_frame_sw;
                            end
                        endcase
                    end
                    if (state_r.mode == rxc_pkg::RXC_ONESHOT) begin
                        for (int k = 0; k < 6; k++) begin
                            state_nxt.relay[k] = (state_nxt.pulse[k] != 32'h0);
                        end
                    end
                end
            endcase
        end

        // completion indications on the mode pins
        state_nxt.a_low = state_nxt.a_hold ||
            ((state_r.mode == rxc_pkg::RXC_REGISTER) && (state_nxt.tmr != 32'h0));
        state_nxt.b_low =
            (state_r.mode == rxc_pkg::RXC_ERASE) && (state_nxt.tmr != 32'h0);

        // ************************************************************
        // bus slave: one wait cycle per access
        // ************************************************************
        state_nxt.ack = (i_avs_read || i_avs_write) && !state_r.ack;
        if (i_avs_read && !state_r.ack) begin
            if (i_avs_address == `RXC_OFS_STATUS) begin
                state_nxt.rdata = 32'h0;
                state_nxt.rdata[`RXC_ST_MODE_LSB +: 3] = state_r.mode;
                state_nxt.rdata[`RXC_ST_SAMPLED_BIT] = state_r.sampled;
                state_nxt.rdata[`RXC_ST_COUNT_LSB +: 7] = state_r.count;
                state_nxt.rdata[`RXC_ST_RELAY_LSB +: 6] = state_r.relay;
                state_nxt.rdata[`RXC_ST_PIN_A_BIT] = state_r.a_low;
                state_nxt.rdata[`RXC_ST_PIN_B_BIT] = state_r.b_low;
            end else if (i_avs_address == `RXC_OFS_CTRL) begin
                state_nxt.rdata = {31'h0, state_r.ctrl_en};
            end else if (i_avs_address == `RXC_OFS_INDEX) begin
                state_nxt.rdata = {25'h0, state_r.idx};
            end else if (i_avs_address == `RXC_OFS_ENTRY) begin
                if (state_r.idx < state_r.count) begin
                    state_nxt.rdata = state_r.ids[state_r.idx];
                end else begin
                    state_nxt.rdata = 32'h0;
                end
            end else begin
                state_nxt.rdata = 32'h0;
            end
        end
        if (i_avs_write && state_r.ack && i_avs_byteenable[0]) begin
            if (i_avs_address == `RXC_OFS_CTRL) begin
                state_nxt.ctrl_en = i_avs_writedata[`RXC_CTRL_EN_BIT];
            end else if (i_avs_address == `RXC_OFS_INDEX) begin
                state_nxt.idx = i_avs_writedata[6:0];
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            // list and count kept over power-up, blank part needs one erase-all
            state_r.sampled <= 1'b0;
            state_r.mode <= rxc_pkg::RXC_IDLE;
            state_r.tmr <= 32'h0;
            state_r.a_low <= 1'b0;
            state_r.a_hold <= 1'b0;
            state_r.b_low <= 1'b0;
            state_r.sw_last <= 6'h00;
            state_r.relay <= 6'h00;
            state_r.pulse <= '0;
            state_r.ctrl_en <= `RXC_CTRL_RESET;
            state_r.idx <= 7'h00;
            state_r.ack <= 1'b0;
            state_r.rdata <= 32'h0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign o_mode_pin_a = 1'b0;
    assign o_mode_pin_a_oe = state_r.sampled && state_r.a_low;
    assign o_mode_pin_b = 1'b0;
    assign o_mode_pin_b_oe = state_r.sampled && state_r.b_low;
    assign o_relay = state_r.relay;
    assign o_avs_readdata = state_r.ack ? state_r.rdata : 32'h0;
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !state_r.ack;

endmodule : rxc_top

`default_nettype wire

/* tb/rxc_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module rxc_properties (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // mode pins
    input wire logic i_set_pin,
    input wire logic i_mode_pin_a,
    input wire logic i_mode_pin_b,
    input wire logic o_mode_pin_a_oe,
    input wire logic o_mode_pin_b_oe,
    // frames and relays
    input wire logic i_frame_valid,
    input wire logic [5:0] i_frame_sw,
    input wire logic [5:0] o_relay
);
    logic smp_r;
    logic [2:0] md_r;
    // ************************************************************
    // mode seen at first edge
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            smp_r <= 1'b0;
            md_r <= 3'h0;
        end else if (!smp_r) begin
            smp_r <= 1'b1;
            md_r <= {i_set_pin, i_mode_pin_b, i_mode_pin_a};
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    property p_reg; md_r == 3'h3 && $rose(o_mode_pin_a_oe) |-> $past(i_frame_valid); endproperty
    a_reg: assert property (p_reg) else $error("pin a without frame");
    property p_done; $rose(o_mode_pin_a_oe) |=> o_mode_pin_a_oe [*8]; endproperty
    a_done: assert property (p_done) else $error("pin a too short");
    property p_ers; $rose(o_mode_pin_b_oe) |-> md_r == 3'h2 && $past(i_frame_valid); endproperty
    a_ers: assert property (p_ers) else $error("pin b wrong");
    property p_all; smp_r && md_r == 3'h1 && o_mode_pin_a_oe |=> o_mode_pin_a_oe; endproperty
    a_all: assert property (p_all) else $error("pin a released");
    property p_norm; smp_r && md_r[2] |-> !o_mode_pin_a_oe && !o_mode_pin_b_oe; endproperty
    a_norm: assert property (p_norm) else $error("pin driven in normal");
    property p_one;
        md_r == 3'h7 && $rose(o_relay[0]) |-> $past(i_frame_sw[0]) ##1 o_relay[0] [*6];
    endproperty
    a_one: assert property (p_one) else $error("pulse wrong");
    property p_tog; md_r == 3'h6 && $changed(o_relay) |-> $past(i_frame_valid); endproperty
    a_tog: assert property (p_tog) else $error("toggle no frame");
    property p_sw;
        md_r == 3'h5 |-> o_relay[2:0] == 3'h0 && (!$rose(o_relay[3]) || $past(i_frame_sw[0]));
    endproperty
    a_sw: assert property (p_sw) else $error("switch wrong");
    property p_cont;
        md_r == 3'h4 && $changed(o_relay) |-> $past(i_frame_valid) && o_relay == $past(i_frame_sw);
    endproperty
    a_cont: assert property (p_cont) else $error("follow wrong");
    c_reg: cover property ($rose(o_mode_pin_a_oe));
    c_ers: cover property ($rose(o_mode_pin_b_oe));
    c_sw: cover property (md_r == 3'h5 && $rose(o_relay[5]));
endmodule : rxc_properties
bind rxc_top rxc_properties u_props (.i_clk(i_clk), .i_rstn(i_rstn), .i_set_pin(i_set_pin),
    .i_mode_pin_a(i_mode_pin_a), .i_mode_pin_b(i_mode_pin_b), .o_mode_pin_a_oe(o_mode_pin_a_oe),
    .o_mode_pin_b_oe(o_mode_pin_b_oe), .i_frame_valid(i_frame_valid), .i_frame_sw(i_frame_sw),
    .o_relay(o_relay));
`default_nettype wire

/* tb/rxc_tx_model.sv */
`timescale 1ns/10ps
`default_nettype none
module rxc_tx_model (
    // clock
    input wire logic i_clk,
    // frame
    output logic o_valid,
    output logic [31:0] o_id,
    output logic [5:0] o_sw
);
    initial begin
        o_valid = 1'b0;
        o_id = 32'h0;
        o_sw = 6'h0;
    end
    task automatic send(input logic [31:0] id, input logic [5:0] sw);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_id <= id;
        o_sw <= sw;
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_id <= ~id;
        o_sw <= ~sw;
    endtask : send
endmodule : rxc_tx_model
`default_nettype wire

/* tb/rxc_top_test.sv */
`timescale 1ns/10ps
`default_nettype none
module rxc_top_test;
    localparam int DEP = 4;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] pins = 3'h7;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] seed = 32'hEDC7;
    logic oe_a, oe_b, wreq, fv;
    logic dra, drb;
    logic [31:0] fid, rdo, rdat;
    logic [5:0] fsw, rel, r, p, s;
    logic [31:0] ids[5];
    logic [31:0] q[$];
    int n_errors = 0;
    int checks_done = 0;
    wire pa = oe_a ? dra : pins[0];
    wire pb = oe_b ? drb : pins[1];
    always #12.5 clk = ~clk;
    rxc_top #(.P_DEPTH(DEP), .P_DONE_CYC(32'h14), .P_PULSE_CYC(32'h8), .P_ERASE_ALL_CYC(32'h1E))
    dut (.i_clk(clk), .i_rstn(rstn), .i_set_pin(pins[2]), .i_mode_pin_a(pa), .o_mode_pin_a(dra),
        .o_mode_pin_a_oe(oe_a), .i_mode_pin_b(pb), .o_mode_pin_b(drb), .o_mode_pin_b_oe(oe_b),
        .i_frame_valid(fv), .i_frame_id(fid), .i_frame_sw(fsw), .o_relay(rel),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdo), .o_avs_waitrequest(wreq));
    rxc_tx_model tx (.i_clk(clk), .o_valid(fv), .o_id(fid), .o_sw(fsw));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [5:0] nx(input int m, input logic [5:0] r, p, s);
        logic [5:0] u;
        u = s & ~p;
        case (m)
            0: return u;
            1: return r ^ u;
            2: return {u[4] | r[5] & ~u[5], u[2] | r[4] & ~u[3], u[0] | r[3] & ~u[1], 3'h0};
            default: return s;
        endcase
    endfunction : nx
    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        rd <= ~w;
        wr <= w;
        adr <= a;
        wdat <= d;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (wreq !== 1'b0 && i < 10);
        rdat = rdo;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
        if (i >= 10) begin
            n_errors++;
            wrap_up();
        end
    endtask : bus
    task automatic boot(input logic [2:0] m);
        rstn <= 1'b0;
        pins <= m;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : boot
    task automatic put(input logic [31:0] id, input logic ins);
        int f[$];
        f = q.find_first_index(x) with (x === id);
        if (f.size() > 0) q.delete(f[0]);
        if (ins) q.push_front(id);
        if (q.size() > DEP) void'(q.pop_back());
    endtask : put
    task automatic cmpl();
        bus(1'b0, 4'h0, 32'h0);
        chk({25'h0, rdat[14:8]}, 32'(q.size()));
        for (int k = 0; k <= DEP; k++) begin
            bus(1'b1, 4'h8, 32'(k));
            bus(1'b0, 4'hC, 32'h0);
            chk(rdat, k < q.size() ? q[k] : 32'h0);
        end
    endtask : cmpl
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up();
    end
    initial begin
        for (int k = 0; k < 5; k++) ids[k] = rnd();
        boot(3'h1);
        repeat (40) @(posedge clk);
        bus(1'b0, 4'h0, 32'h0);
        chk({25'h0, rdat[14:8]}, 32'h0);
        boot(3'h3);
        bus(1'b0, 4'h4, 32'h0);
        chk(rdat, 32'h1);
        bus(1'b0, 4'h2, 32'h0);
        chk(rdat, 32'h0);
        for (int k = 0; k < 6; k++) begin
            tx.send(ids[k < 5 ? k : 2], 6'h0);
            @(posedge clk);
            put(ids[k < 5 ? k : 2], 1'b1);
            chk(oe_a, 1'b1);
            chk(pa, 1'b0);
        end
        cmpl();
        repeat (24) @(posedge clk);
        chk(oe_a, 1'b0);
        boot(3'h2);
        tx.send(ids[4], 6'h0);
        @(posedge clk);
        put(ids[4], 1'b0);
        chk(oe_b, 1'b1);
        chk(pb, 1'b0);
        cmpl();
        for (int m = 0; m < 4; m++) begin
            boot({1'b1, ~2'(m)});
            r = 6'h0;
            p = 6'h0;
            for (int j = 0; j < 12; j++) begin
                s = (j == 0) ? 6'h3F : 6'(rnd());
                tx.send(q[0], s);
                @(posedge clk);
                r = nx(m, r, p, s);
                p = s;
                chk(rel, r);
                chk(oe_a | oe_b, 1'b0);
                repeat (10) @(posedge clk);
            end
            bus(1'b1, 4'h4, 32'h0);
            tx.send(q[0], ~p);
            @(posedge clk);
            chk(rel, m == 0 ? 6'h0 : r);
        end
        boot(3'h1);
        repeat (40) @(posedge clk);
        chk(oe_a, 1'b1);
        bus(1'b0, 4'h0, 32'h0);
        chk({25'h0, rdat[14:8]}, 32'h0);
        wrap_up();
    end
endmodule : rxc_top_test
`default_nettype wire
